// *** hw/crs_clock_ratio_select_unit.sv ***
// Top of the clock ratio select unit: register, clamping and three clocks.
//
// Function
// - Three clocks come from one source: core, peripheral and external bus.
// - Each clock's ratio is chosen on its own, only clamped against the core clock.
// - Writing new ratio codes into the control register changes the clocks.
// - Bit 15 at 0 drives the bus clock onto its pin (a x4 bus code shows there at the x2 rate), at 1 holds the pin high.
// - Bits 14 to 11, 7 and 3 read as zero and software writes zero to them.
// - Core code in bits 10 to 8: 000 x4, 001 x2, 010 x1, 011 x1/2, 1XX forbidden.
// - The core clock goes to the processor and the data transfer controller.
// - A peripheral or bus clock faster than the core clock runs at the core rate.
// - Peripheral code in bits 6 to 4 uses the core encoding, 1XX forbidden.
// - A peripheral setting above the core rate is accepted but runs at the core rate.
// - Bus code in bits 2 to 0 uses the same encoding and is clamped to the core.
// - The oscillator clock is multiplied by four before it is divided.
// - A new setting waits for the bus cycle, then applies within one input clock.
//
// The register addresses and the strobed register port were chosen for this implementation.
module crs_clock_ratio_select_unit
(
    // Clock and reset; clk is the multiplied clock, four times the input clock
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [crs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [crs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [crs_pkg::DATA_W-1:0] reg_rdata,
    // Bus cycle status from the bus controller
    input wire logic bus_cycle_busy,
    // Derived clocks as one-cycle ticks of clk
    output logic core_tick,
    output logic periph_tick,
    output logic extbus_tick,
    // Bus clock pin and applied state
    output logic bus_clock_pin,
    output logic change_pending,
    output logic [9:0] applied_setting
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [15:0] control_r;
    logic [15:0] control_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    crs_pkg::crs_setting_s active_r;
    crs_pkg::crs_setting_s active_nxt;
    logic [crs_pkg::REF_CNT_W-1:0] ref_cnt_r;
    logic [crs_pkg::REF_CNT_W-1:0] ref_cnt_nxt;
    logic pin_r;
    logic pin_nxt;
    logic [2:0] eff_core;
    logic [2:0] eff_periph;
    logic [2:0] eff_extbus;
    logic wr_hit;
    logic apply;
    logic pending;
    logic core_tick_i;
    logic periph_tick_i;
    logic extbus_tick_i;
    logic extbus_phase;
    logic core_phase;
    logic periph_phase;

    assign wr_hit = reg_wr && (reg_addr == crs_pkg::CLOCK_RATIO_CONTROL_ADDR);

    // ------------------------------------------------------------------
    // Control register write
    // ------------------------------------------------------------------
    // A forbidden 1XX code leaves that field unchanged rather than storing a
    // code the dividers cannot serve; the other fields still take the write.
    always_comb
    begin
        control_nxt = control_r;
        if (wr_hit)
        begin
            control_nxt[crs_pkg::HOLD_HIGH_BIT] = reg_wdata[crs_pkg::HOLD_HIGH_BIT];
            if (!reg_wdata[crs_pkg::CORE_LSB+2])
            begin
                control_nxt[crs_pkg::CORE_LSB +: 3] = reg_wdata[crs_pkg::CORE_LSB +: 3];
            end
            if (!reg_wdata[crs_pkg::PERIPH_LSB+2])
            begin
                control_nxt[crs_pkg::PERIPH_LSB +: 3] = reg_wdata[crs_pkg::PERIPH_LSB +: 3];
            end
            if (!reg_wdata[crs_pkg::EXTBUS_LSB+2])
            begin
                control_nxt[crs_pkg::EXTBUS_LSB +: 3] = reg_wdata[crs_pkg::EXTBUS_LSB +: 3];
            end
        end
        control_nxt = control_nxt & crs_pkg::WRITABLE_MASK;
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (reg_rd && (reg_addr == crs_pkg::CLOCK_RATIO_CONTROL_ADDR))
        begin
            rdata_nxt = control_r & crs_pkg::WRITABLE_MASK;
        end
    end

    // Register file and read data.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            control_r <= crs_pkg::CONTROL_RESET;
            rdata_r <= 16'h0000;
        end
        else
        begin
            control_r <= control_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Clamping against the core clock
    // ------------------------------------------------------------------
    // A larger code is a slower clock, so the effective code is the larger of
    // the two; the core setting wins only when it is the slower.
    always_comb
    begin
        eff_core = control_r[crs_pkg::CORE_LSB +: 3];
        eff_periph = control_r[crs_pkg::PERIPH_LSB +: 3];
        eff_extbus = control_r[crs_pkg::EXTBUS_LSB +: 3];
        if (eff_periph < eff_core)
        begin
            eff_periph = eff_core;
        end
        if (eff_extbus < eff_core)
        begin
            eff_extbus = eff_core;
        end
    end

    // ------------------------------------------------------------------
    // Change control: hold the write until the bus cycle ends
    // ------------------------------------------------------------------
    crs_apply_ctl u_apply
    (
        .clk(clk),
        .rstn(rstn),
        .write_event(wr_hit),
        .bus_cycle_busy(bus_cycle_busy),
        .ref_cnt(ref_cnt_r),
        .pending_r(pending),
        .apply_r(apply)
    );

    // The applied setting changes only on the apply pulse, so a write during a
    // bus cycle never retimes that cycle.
    always_comb
    begin
        active_nxt = active_r;
        if (apply)
        begin
            active_nxt.hold_high = control_r[crs_pkg::HOLD_HIGH_BIT];
            active_nxt.core = eff_core;
            active_nxt.periph = eff_periph;
            active_nxt.extbus = eff_extbus;
        end
    end

    // ------------------------------------------------------------------
    // Reference count: one input clock is four fast cycles
    // ------------------------------------------------------------------
    always_comb
    begin
        ref_cnt_nxt = ref_cnt_r + 3'h1;
    end

    // Register applied setting and reference count.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_r <= '{crs_pkg::HOLD_HIGH_RESET, crs_pkg::RATIO_RESET,
                crs_pkg::RATIO_RESET, crs_pkg::RATIO_RESET};
            ref_cnt_r <= 3'h0;
        end
        else
        begin
            active_r <= active_nxt;
            ref_cnt_r <= ref_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Three derived clocks from the one reference count
    // ------------------------------------------------------------------
    crs_tick_gen u_core
    (
        .clk(clk),
        .rstn(rstn),
        .ref_cnt(ref_cnt_r),
        .code(active_r.core),
        .tick_r(core_tick_i),
        .phase_r(core_phase)
    );

    crs_tick_gen u_periph
    (
        .clk(clk),
        .rstn(rstn),
        .ref_cnt(ref_cnt_r),
        .code(active_r.periph),
        .tick_r(periph_tick_i),
        .phase_r(periph_phase)
    );

    crs_tick_gen u_extbus
    (
        .clk(clk),
        .rstn(rstn),
        .ref_cnt(ref_cnt_r),
        .code(active_r.extbus),
        .tick_r(extbus_tick_i),
        .phase_r(extbus_phase)
    );

    // Bus clock pin: driven clock level, or held high.
    always_comb
    begin
        pin_nxt = active_r.hold_high ? 1'b1 : extbus_phase;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_r <= 1'b0;
        end
        else
        begin
            pin_r <= pin_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign core_tick = core_tick_i;
    assign periph_tick = periph_tick_i;
    assign extbus_tick = extbus_tick_i;
    assign bus_clock_pin = pin_r;
    assign change_pending = pending;
    assign applied_setting = active_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_reserved_zero;
        @(posedge clk) disable iff (!rstn)
        $past(reg_rd) |-> ((reg_rdata & ~crs_pkg::WRITABLE_MASK) == 16'h0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved control bits read nonzero.");

    property p_clamp_periph;
        @(posedge clk) disable iff (!rstn)
        active_r.periph >= active_r.core;
    endproperty
    a_clamp_periph: assert property (p_clamp_periph)
        else $error("Peripheral clock faster than core clock.");

    property p_clamp_extbus;
        @(posedge clk) disable iff (!rstn)
        active_r.extbus >= active_r.core;
    endproperty
    a_clamp_extbus: assert property (p_clamp_extbus)
        else $error("Bus clock faster than core clock.");

    property p_hold_high;
        @(posedge clk) disable iff (!rstn)
        active_r.hold_high |=> bus_clock_pin;
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("Bus clock pin not held high.");

    property p_no_apply_busy;
        @(posedge clk) disable iff (!rstn)
        $rose(apply) |-> !$past(bus_cycle_busy);
    endproperty
    a_no_apply_busy: assert property (p_no_apply_busy)
        else $error("Setting applied during a bus cycle.");

    property p_apply_bound;
        @(posedge clk) disable iff (!rstn)
        (pending && !bus_cycle_busy) [*4] |-> ##[0:1] apply;
    endproperty
    a_apply_bound: assert property (p_apply_bound)
        else $error("Setting not applied within one input clock.");

    property p_write_takes;
        @(posedge clk) disable iff (!rstn)
        (wr_hit && !reg_wdata[10]) |=> (control_r[10:8] == $past(reg_wdata[10:8]));
    endproperty
    a_write_takes: assert property (p_write_takes)
        else $error("Core ratio write not stored.");

    property p_core_rate;
        @(posedge clk) disable iff (!rstn)
        (active_r.core == crs_pkg::RATIO_X4) [*2] |-> core_tick;
    endproperty
    a_core_rate: assert property (p_core_rate)
        else $error("Core tick missing at times four.");

    property p_no_forbidden;
        @(posedge clk) disable iff (!rstn)
        !control_r[10] && !control_r[6] && !control_r[2];
    endproperty
    a_no_forbidden: assert property (p_no_forbidden)
        else $error("Forbidden ratio code stored.");

endmodule // crs_clock_ratio_select_unit

// *** hw/crs_pkg.sv ***
// Package of constants and types for the clock ratio select unit.
package crs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [3:0] CLOCK_RATIO_CONTROL_ADDR = 4'h0;

    // ------------------------------------------------------------------
    // Field positions of clock_ratio_control
    // ------------------------------------------------------------------
    localparam int unsigned HOLD_HIGH_BIT = 15;
    localparam int unsigned CORE_LSB = 8;
    localparam int unsigned PERIPH_LSB = 4;
    localparam int unsigned EXTBUS_LSB = 0;
    localparam int unsigned RATIO_W = 3;
    localparam logic [15:0] WRITABLE_MASK = 16'h8777;

    // ------------------------------------------------------------------
    // Ratio codes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] RATIO_X4 = 3'h0;
    localparam logic [2:0] RATIO_X2 = 3'h1;
    localparam logic [2:0] RATIO_X1 = 3'h2;
    localparam logic [2:0] RATIO_HALF = 3'h3;
    localparam logic [2:0] RATIO_RESET = RATIO_X1;
    localparam logic HOLD_HIGH_RESET = 1'b0;
    localparam logic [15:0] CONTROL_RESET = 16'h0222;

    // ------------------------------------------------------------------
    // Timing: fast clock is the input clock multiplied by a fixed factor
    // ------------------------------------------------------------------
    localparam int unsigned PLL_FACTOR = 4;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned INPUT_CLK_PERIOD_NS = CLK_PERIOD_NS * PLL_FACTOR;
    localparam int unsigned INPUT_CLK_CYCLES = INPUT_CLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned REF_CNT_W = 3;
    localparam logic [1:0] INPUT_CLK_LAST = 2'h3;

    // Applied clock setting, moved as one unit.
    typedef struct packed {
        logic hold_high;
        logic [2:0] core;
        logic [2:0] periph;
        logic [2:0] extbus;
    } crs_setting_s;

endpackage

// *** hw/crs_tick_gen.sv ***
// Divided clock tick and phase generator for one derived clock.
module crs_tick_gen
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Shared reference count and selected ratio code
    input wire logic [crs_pkg::REF_CNT_W-1:0] ref_cnt,
    input wire logic [2:0] code,
    // Derived clock
    output logic tick_r,
    output logic phase_r
);

    logic tick_nxt;
    logic phase_nxt;
    logic [crs_pkg::REF_CNT_W-1:0] mask;

    // ------------------------------------------------------------------
    // Tick when the low code bits of the count are all ones.
    // ------------------------------------------------------------------
    always_comb
    begin
        mask = 3'h0;
        phase_nxt = ~ref_cnt[0];
        unique case (code)
            3'h0:
            begin
                mask = 3'h0;
                phase_nxt = ~ref_cnt[0];
            end
            3'h1:
            begin
                mask = 3'h1;
                phase_nxt = ~ref_cnt[0];
            end
            3'h2:
            begin
                mask = 3'h3;
                phase_nxt = ~ref_cnt[1];
            end
            3'h3:
            begin
                mask = 3'h7;
                phase_nxt = ~ref_cnt[2];
            end
            // A forbidden code is never stored; should one arrive, run at the slowest rate.
            default:
            begin
                mask = 3'h7;
                phase_nxt = ~ref_cnt[2];
            end
        endcase
        tick_nxt = ((ref_cnt & mask) == mask);
    end

    // Register the tick and the level so the outputs are glitch free.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tick_r <= 1'b0;
            phase_r <= 1'b0;
        end
        else
        begin
            tick_r <= tick_nxt;
            phase_r <= phase_nxt;
        end
    end

endmodule // crs_tick_gen

// *** hw/crs_apply_ctl.sv ***
// Holds a written setting until the bus cycle ends and an input clock edge comes.
module crs_apply_ctl
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Events
    input wire logic write_event,
    input wire logic bus_cycle_busy,
    input wire logic [crs_pkg::REF_CNT_W-1:0] ref_cnt,
    // Result
    output logic pending_r,
    output logic apply_r
);

    logic pending_nxt;
    logic apply_nxt;
    logic fire;

    // ------------------------------------------------------------------
    // Fire at the last fast cycle of an input clock period once idle.
    // A write in the firing cycle keeps the request pending (set wins).
    // ------------------------------------------------------------------
    always_comb
    begin
        fire = pending_r && !bus_cycle_busy && (ref_cnt[1:0] == crs_pkg::INPUT_CLK_LAST);
        apply_nxt = fire;
        pending_nxt = write_event || (pending_r && !fire);
    end

    // Register the request state.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pending_r <= 1'b0;
            apply_r <= 1'b0;
        end
        else
        begin
            pending_r <= pending_nxt;
            apply_r <= apply_nxt;
        end
    end

endmodule // crs_apply_ctl

// *** testbench/tb_top.sv ***
// Self-checking testbench of the clock ratio select unit with a queue-free reference model.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk;
    logic rstn;
    logic [crs_pkg::ADDR_W-1:0] reg_addr;
    logic [crs_pkg::DATA_W-1:0] reg_wdata;
    logic [crs_pkg::DATA_W-1:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic bus_cycle_busy;
    logic core_tick;
    logic periph_tick;
    logic extbus_tick;
    logic bus_clock_pin;
    logic change_pending;
    logic [9:0] applied_setting;
    int bad_count;
    int cmp_count;
    logic [15:0] m_ctrl;
    logic [15:0] d;
    logic [9:0] old_set;

    crs_clock_ratio_select_unit dut
    (
        .clk(clk),
        .rstn(rstn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .bus_cycle_busy(bus_cycle_busy),
        .core_tick(core_tick),
        .periph_tick(periph_tick),
        .extbus_tick(extbus_tick),
        .bus_clock_pin(bus_clock_pin),
        .change_pending(change_pending),
        .applied_setting(applied_setting)
    );

    // The fast clock runs at 40 MHz.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // A field written with its top bit set keeps its old value, reserved bits are never kept.
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a === crs_pkg::CLOCK_RATIO_CONTROL_ADDR)
        begin
            m_ctrl[15] = v[15];
            for (int f = 0; f < 12; f += 4)
            begin
                if (v[f+2] !== 1'b1)
                    m_ctrl[f+:3] = v[f+:3];
            end
        end
    endtask

    // Read data stand only in the cycle after the strobe, then fall back to zero.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("read_data", exp, reg_rdata);
        @(negedge clk);
        chk("read_idle", 16'h0000, reg_rdata);
    endtask

    // Faster clocks are clamped to the core rate; a larger code means a slower clock.
    function automatic logic [9:0] exp_set();
        logic [2:0] c;
        logic [2:0] p;
        logic [2:0] e;
        c = m_ctrl[10:8];
        p = (m_ctrl[6:4] < c) ? c : m_ctrl[6:4];
        e = (m_ctrl[2:0] < c) ? c : m_ctrl[2:0];
        return {m_ctrl[15], c, p, e};
    endfunction

    // The wait is bounded: a change must land within six fast cycles once the wait starts.
    task automatic wait_apply(input int limit);
        int n;
        n = 0;
        while (applied_setting !== exp_set() && n < limit)
        begin
            @(negedge clk);
            n++;
        end
        chk("applied_setting", {6'h00, exp_set()}, {6'h00, applied_setting});
    endtask

    // The third interval is taken so that the change-over period is skipped.
    task automatic period(input int sel, input logic [2:0] code);
        logic [2:0] t;
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                t = {core_tick, periph_tick, extbus_tick};
                n++;
            end while (t[sel] !== 1'b1 && n < 20);
        end
        chk("tick_period", 16'h0001 << code, n[15:0]);
    endtask

    // A square wave spends half of any 16-cycle window high; a held pin spends all of it.
    task automatic pin_check();
        int ones;
        ones = 0;
        repeat (16)
        begin
            @(negedge clk);
            ones += (bus_clock_pin === 1'b1);
        end
        chk("pin_high_count", m_ctrl[15] ? 16'h0010 : 16'h0008, ones[15:0]);
    endtask

    task automatic full_check();
        logic [9:0] s;
        wait_apply(6);
        s = exp_set();
        period(2, s[8:6]);
        period(1, s[5:3]);
        period(0, s[2:0]);
        pin_check();
    endtask

    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bus_cycle_busy = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        m_ctrl = 16'h0222;
        void'($urandom(32'h6277bc80));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("reset_setting", 16'h0092, {6'h00, applied_setting});
        rd(4'h0, 16'h0222);
        full_check();
        // Every core code with the fastest peripheral and slowest bus request.
        for (int c = 0; c < 4; c++)
        begin
            wr(4'h0, {5'h00, c[2:0], 8'h03});
            rd(4'h0, m_ctrl);
            full_check();
        end
        wr(4'h0, 16'h8444);
        rd(4'h0, m_ctrl);
        full_check();
        wr(4'h0, 16'h7888);
        rd(4'h0, 16'h0000);
        full_check();
        wr(4'h5, 16'h0333);
        rd(4'h5, 16'h0000);
        rd(4'h0, m_ctrl);
        // A write during a bus cycle must not take effect until the cycle ends.
        old_set = exp_set();
        @(posedge clk);
        bus_cycle_busy <= 1'b1;
        wr(4'h0, 16'h0123);
        repeat (10) @(negedge clk);
        chk("pending_busy", 16'h0001, {15'h0000, change_pending});
        chk("held_setting", {6'h00, old_set}, {6'h00, applied_setting});
        @(posedge clk);
        bus_cycle_busy <= 1'b0;
        full_check();
        // Random words, forbidden codes and reserved bits among them.
        repeat (12)
        begin
            d = 16'($urandom);
            wr(4'h0, d);
            rd(4'h0, m_ctrl);
            full_check();
        end
        // A second reset in mid-run restores the reset values.
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        m_ctrl = 16'h0222;
        rd(4'h0, 16'h0222);
        chk("reset_setting", 16'h0092, {6'h00, applied_setting});
        results();
    end

    // The watchdog cuts a hang short well beyond the expected few thousand cycles.
    initial
    begin
        #500000;
        bad_count++;
        results();
    end
endmodule // tb_top
